// File: stmc_chk.sv
// port assertions for the sweep trigger mode controller
`timescale 1ns/1ps
`include "stmc_map.vh"
module stmc_chk #(
   parameter PEAKW = 8
) (
   input wire             clk_sys,
   input wire             reset_n,
   input wire             psel,
   input wire             penable,
   input wire             pwrite,
   input wire [11:0]      paddr,
   input wire [31:0]      pwdata,
   input wire             splitTrace,
   input wire             delayExpired,
   input wire             sweepDone,
   input wire [PEAKW-1:0] peakHigh,
   input wire [PEAKW-1:0] peakLow,
   input wire             dlySweepGo,
   input wire             armedLamp,
   input wire [2:0]       mainTrigSrc,
   input wire [2:0]       dlyTrigSrc,
   input wire [PEAKW-1:0] cursorHigh,
   input wire [PEAKW-1:0] cursorLow
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire apbWr     = psel && penable && pwrite;
   wire cmdWr     = apbWr && (paddr == `STMC_ADDR_CMD);
   wire modeDnWr  = cmdWr && pwdata[`STMC_CMD_MODEDN];
   wire voltsWr   = cmdWr && pwdata[`STMC_CMD_VOLTS];
   dly_run_a: assert property ($rose(dlySweepGo) |-> $past(splitTrace))
      else $error("delayed sweep started while main sweep idle");
   dly_delay_a: assert property ($rose(dlySweepGo) |-> $past(delayExpired))
      else $error("delayed sweep started before delay ran out");
   armed_hold_a: assert property ($fell(armedLamp) |-> $past(sweepDone) || $past(apbWr))
      else $error("armed light dropped without a finished trace");
   armed_cause_a: assert property ($rose(armedLamp) |-> $past(modeDnWr) || $past(modeDnWr, 2))
      else $error("armed light rose without a mode-down press");
   cursor_cause_a: assert property (($changed(cursorHigh) || $changed(cursorLow))
      |-> $past(voltsWr) || $past(voltsWr, 2))
      else $error("cursors moved without a volts command");
   cursor_peak_a: assert property ($changed(cursorHigh)
      |-> cursorHigh == $past(peakHigh))
      else $error("upper cursor not at upper peak");
   main_src_a: assert property (mainTrigSrc <= 3'h6)
      else $error("main trigger source out of range");
   dly_src_a: assert property (dlyTrigSrc <= 3'h6)
      else $error("delayed trigger source out of range");
   cover property ($rose(dlySweepGo));
   cover property ($rose(armedLamp));
   cover property ($fell(armedLamp));
endmodule // stmc_chk

bind stmc_sweep_trigger stmc_chk #(.PEAKW(PEAKW)) stmc_chk_inst (
   .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .splitTrace(splitTrace), .delayExpired(delayExpired),
   .sweepDone(sweepDone), .peakHigh(peakHigh), .peakLow(peakLow), .dlySweepGo(dlySweepGo),
   .armedLamp(armedLamp), .mainTrigSrc(mainTrigSrc), .dlyTrigSrc(dlyTrigSrc),
   .cursorHigh(cursorHigh), .cursorLow(cursorLow));

// File: stmc_far_side.sv
// comparators and sweep circuit on the far side of the controller
`timescale 1ns/1ps
module stmc_far_side #(
   parameter PEAKW = 8
) (
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire             runMain,
   input  wire             doneReq,
   input  wire [3:0]       lat,
   input  wire [PEAKW-1:0] peakSet,
   output reg              trigMain,
   output reg              trigDly,
   output reg              videoLine,
   output reg              videoField,
   output reg              signalAdequate,
   output reg              levelEndStop,
   output reg              delayExpired,
   output reg              sweepDone,
   output reg              splitTrace,
   output wire [PEAKW-1:0] peakHigh,
   output wire [PEAKW-1:0] peakLow
);
   reg [3:0] tick;
   reg [3:0] doneCnt;
   reg [3:0] dlyCnt;
   assign peakHigh = peakSet;
   assign peakLow  = peakSet >> 1;
   // lat sets how slowly a trace or the delay completes
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         {trigMain, trigDly, videoLine, videoField, signalAdequate} <= 5'h00;
         {levelEndStop, delayExpired, sweepDone, splitTrace} <= 4'h0;
         tick    <= 4'h0;
         doneCnt <= 4'h0;
         dlyCnt  <= 4'h0;
      end else begin
         tick           <= tick + 4'h1;
         trigMain       <= (tick == 4'h3);
         trigDly        <= (tick == 4'h9) && splitTrace;
         videoLine      <= (tick[1:0] == 2'h0);
         videoField     <= (tick == 4'h0);
         signalAdequate <= 1'b1;
         splitTrace     <= runMain;
         dlyCnt         <= !runMain ? 4'h0 : (dlyCnt == lat) ? dlyCnt : dlyCnt + 4'h1;
         delayExpired   <= runMain && (dlyCnt == lat);
         if (doneReq) begin
            doneCnt <= lat;
         end else if (doneCnt != 4'h0) begin
            doneCnt <= doneCnt - 4'h1;
         end
         sweepDone <= (doneCnt == 4'h1);
      end
   end
endmodule // stmc_far_side

// File: stmc_map.vh
// constants for the sweep trigger mode controller
`ifndef STMC_MAP_VH
`define STMC_MAP_VH
// --------------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------------
`define STMC_ADDR_CTRL    12'h000
`define STMC_ADDR_MAINCFG 12'h004
`define STMC_ADDR_DLYCFG  12'h008
`define STMC_ADDR_DISP    12'h00C
`define STMC_ADDR_CMD     12'h010
`define STMC_ADDR_STATUS  12'h014
`define STMC_ADDR_MEAS    12'h018
// --------------------------------------------------------------------
// main trigger modes
// --------------------------------------------------------------------
`define STMC_MM_SELFLVL  3'h0
`define STMC_MM_FREERUN  3'h1
`define STMC_MM_ARMED    3'h2
`define STMC_MM_VLINE    3'h3
`define STMC_MM_VFIELD   3'h4
`define STMC_MM_ONESHOT  3'h5
`define STMC_MM_LAST     3'h5
// --------------------------------------------------------------------
// delayed trigger modes
// --------------------------------------------------------------------
`define STMC_DM_SELFLVL  3'h0
`define STMC_DM_START    3'h1
`define STMC_DM_ARMED    3'h2
`define STMC_DM_VLINE    3'h3
`define STMC_DM_LAST     3'h3
// --------------------------------------------------------------------
// sources, couplings, horizontal modes
// --------------------------------------------------------------------
`define STMC_SRC_DISP    3'h0
`define STMC_SRC_LAST    3'h5
`define STMC_SRC_SUM     3'h6
`define STMC_CPL_LAST    3'h4
`define STMC_HM_MAIN     2'h0
`define STMC_HM_INTL     2'h1
`define STMC_HM_DLY      2'h2
`define STMC_HM_XY       2'h3
// --------------------------------------------------------------------
// command bits, reset values, timing
// --------------------------------------------------------------------
`define STMC_CMD_MODEUP  0
`define STMC_CMD_MODEDN  1
`define STMC_CMD_SRCUP   2
`define STMC_CMD_SRCDN   3
`define STMC_CMD_CPLUP   4
`define STMC_CMD_CPLDN   5
`define STMC_CMD_CLEAR   6
`define STMC_CMD_VOLTS   7
`define STMC_CMD_TIME    8
`define STMC_CMD_SLOPE   9
`define STMC_RST_SEQLEN  3'h1
`define STMC_BRIEF_NS    100000
`define STMC_CLK_NS      5
`endif

// File: stmc_sweep_trigger.v
// sweep trigger mode, source, coupling and measurement control
`timescale 1ns/1ps
`include "stmc_map.vh"

module stmc_sweep_trigger #(
   parameter BRIEF_CYC = (`STMC_BRIEF_NS + `STMC_CLK_NS - 1) / `STMC_CLK_NS,
   parameter PEAKW     = 8
) (
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire             psel,
   input  wire             penable,
   input  wire             pwrite,
   input  wire [11:0]      paddr,
   input  wire [31:0]      pwdata,
   output reg  [31:0]      prdata,
   output wire             pready,
   output wire             pslverr,
   input  wire             trigMain,
   input  wire             trigDly,
   input  wire             videoLine,
   input  wire             videoField,
   input  wire             signalAdequate,
   input  wire             levelEndStop,
   input  wire             delayExpired,
   input  wire             sweepDone,
   input  wire             splitTrace,
   input  wire [PEAKW-1:0] peakHigh,
   input  wire [PEAKW-1:0] peakLow,
   output reg              mainSweepGo,
   output reg              dlySweepGo,
   output reg              levelAcquire,
   output reg              armedLamp,
   output reg              readoutOn,
   output reg  [2:0]       mainTrigSrc,
   output reg  [2:0]       dlyTrigSrc,
   output reg  [PEAKW-1:0] cursorHigh,
   output reg  [PEAKW-1:0] cursorLow
);
// --------------------------------------------------------------------
// state
// --------------------------------------------------------------------
reg  [1:0]  horizMode_reg;
reg  [3:0]  chanShown_reg;
reg         sumOn_reg;
reg         timeSliced_reg;
reg         holdReadout_reg;
reg  [2:0]  seqLen_reg;
reg         selDelayed_reg;
reg  [2:0]  mode_reg   [0:1];
reg  [2:0]  src_reg    [0:1];
reg  [2:0]  cpl_reg    [0:1];
reg         slope_reg  [0:1];
reg         dlySlopeSet_reg;
reg         menuOn_reg;
reg         voltsOn_reg;
reg         timeOn_reg;
reg  [1:0]  voltsChan_reg;
reg         ch2First_reg;
reg  [2:0]  delayChan_reg;
reg  [2:0]  deltaChan_reg;
reg  [2:0]  seqLeft_reg;
reg  [2:0]  rotIdx_reg;
reg  [31:0] briefCnt_reg;
reg  [9:0]  cmd;
wire        wrEn;
wire        intlDisp;
wire [2:0]  mMode;
wire [2:0]  dMode;
wire        sel;
wire        dlyActive;
wire        dlyTrigOk;

// --------------------------------------------------------------------
// helpers
// --------------------------------------------------------------------
function [2:0] stepUp;
   input [2:0] v;
   input [2:0] last;
   begin
      stepUp = (v >= last) ? last : v + 3'h1;
   end
endfunction

function [2:0] stepDn;
   input [2:0] v;
   begin
      stepDn = (v == 3'h0) ? 3'h0 : v - 3'h1;
   end
endfunction

// lowest displayed channel at or above start; sum counts highest
function [2:0] nextShown;
   input [3:0] shown;
   input       sumOn;
   input [2:0] start;
   begin
      if (start <= 3'h1 && shown[0])
         nextShown = 3'h1;
      else if (start <= 3'h2 && shown[1])
         nextShown = 3'h2;
      else if (start <= 3'h3 && shown[2])
         nextShown = 3'h3;
      else if (start <= 3'h4 && shown[3])
         nextShown = 3'h4;
      else if (sumOn)
         nextShown = `STMC_SRC_SUM;
      else
         nextShown = 3'h0;
   end
endfunction

// --------------------------------------------------------------------
// apb slave, zero wait
// --------------------------------------------------------------------
assign pready  = 1'b1;
assign pslverr = 1'b0;
assign wrEn    = psel & penable & pwrite;

always @* begin
   cmd = 10'h000;
   if (wrEn && paddr == `STMC_ADDR_CMD)
      cmd = pwdata[9:0];
end

always @(posedge clk_sys or negedge reset_n) begin
   if (!reset_n) begin
      prdata <= 32'h00000000;
   end else if (psel && !penable && !pwrite) begin
      case (paddr)
         `STMC_ADDR_CTRL:    prdata <= {25'h0, seqLen_reg, holdReadout_reg, 1'b0, horizMode_reg};
         `STMC_ADDR_MAINCFG: prdata <= {22'h0, slope_reg[0], cpl_reg[0], src_reg[0], mode_reg[0]};
         `STMC_ADDR_DLYCFG:  prdata <= {22'h0, slope_reg[1], cpl_reg[1], src_reg[1], mode_reg[1]};
         `STMC_ADDR_DISP:    prdata <= {26'h0, timeSliced_reg, sumOn_reg, chanShown_reg};
         `STMC_ADDR_STATUS:  prdata <= {25'h0, seqLeft_reg, readoutOn, armedLamp,
                                        levelAcquire, selDelayed_reg};
         `STMC_ADDR_MEAS:    prdata <= {21'h0, deltaChan_reg, delayChan_reg, voltsChan_reg,
                                        timeOn_reg, voltsOn_reg, menuOn_reg};
         default:            prdata <= 32'h00000000;
      endcase
   end
end

assign intlDisp  = (horizMode_reg == `STMC_HM_INTL) || (horizMode_reg == `STMC_HM_DLY);
assign sel       = selDelayed_reg;
assign mMode     = mode_reg[0];
assign dMode     = mode_reg[1];
// --------------------------------------------------------------------
// configuration and per-system settings
// --------------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
   if (!reset_n) begin
      horizMode_reg   <= `STMC_HM_MAIN;
      chanShown_reg   <= 4'h1;
      sumOn_reg       <= 1'b0;
      timeSliced_reg  <= 1'b0;
      holdReadout_reg <= 1'b0;
      seqLen_reg      <= `STMC_RST_SEQLEN;
      selDelayed_reg  <= 1'b0;
      mode_reg[0]     <= `STMC_MM_SELFLVL;
      mode_reg[1]     <= `STMC_DM_START;
      src_reg[0]      <= `STMC_SRC_DISP;
      src_reg[1]      <= `STMC_SRC_DISP;
      cpl_reg[0]      <= 3'h0;
      cpl_reg[1]      <= 3'h0;
      slope_reg[0]    <= 1'b1;
      slope_reg[1]    <= 1'b1;
      dlySlopeSet_reg <= 1'b0;
   end else begin
      if (wrEn && paddr == `STMC_ADDR_CTRL) begin
         horizMode_reg   <= pwdata[1:0];
         holdReadout_reg <= pwdata[3];
         seqLen_reg      <= pwdata[6:4];
         selDelayed_reg  <= (pwdata[1:0] == `STMC_HM_INTL)
                            || (pwdata[1:0] == `STMC_HM_DLY)
                            || (pwdata[1:0] == `STMC_HM_XY && selDelayed_reg);
      end
      if (wrEn && paddr == `STMC_ADDR_DISP) begin
         chanShown_reg  <= pwdata[3:0];
         sumOn_reg      <= pwdata[4];
         timeSliced_reg <= pwdata[5];
      end
      if (wrEn && paddr == `STMC_ADDR_STATUS)
         selDelayed_reg <= pwdata[0];
      // down walks main toward one-shot, where further presses only re-arm; delayed stops at video line
      if (cmd[`STMC_CMD_MODEDN])
         mode_reg[sel] <= stepUp(mode_reg[sel],
                                 sel ? `STMC_DM_LAST : `STMC_MM_LAST);
      else if (cmd[`STMC_CMD_MODEUP])
         mode_reg[sel] <= stepDn(mode_reg[sel]);
      if (cmd[`STMC_CMD_SRCUP])
         src_reg[sel] <= stepUp(src_reg[sel], `STMC_SRC_LAST);
      else if (cmd[`STMC_CMD_SRCDN])
         src_reg[sel] <= stepDn(src_reg[sel]);
      if (cmd[`STMC_CMD_CPLUP])
         cpl_reg[sel] <= stepUp(cpl_reg[sel], `STMC_CPL_LAST);
      else if (cmd[`STMC_CMD_CPLDN])
         cpl_reg[sel] <= stepDn(cpl_reg[sel]);
      if (cmd[`STMC_CMD_SLOPE]) begin
         slope_reg[sel] <= ~slope_reg[sel];
         if (sel)
            dlySlopeSet_reg <= 1'b1;
      end
      if (!dlySlopeSet_reg && !(cmd[`STMC_CMD_SLOPE] && sel))
         slope_reg[1] <= slope_reg[0];
   end
end

// --------------------------------------------------------------------
// main sweep control
// --------------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
   if (!reset_n) begin
      mainSweepGo  <= 1'b0;
      levelAcquire <= 1'b0;
      armedLamp    <= 1'b0;
      seqLeft_reg  <= 3'h0;
      readoutOn    <= 1'b1;
      briefCnt_reg <= 32'h00000000;
   end else begin
      levelAcquire <= (mMode == `STMC_MM_SELFLVL || dMode == `STMC_DM_SELFLVL)
                      && (!signalAdequate || levelEndStop
                          || (cmd[`STMC_CMD_MODEUP] | cmd[`STMC_CMD_MODEDN]));
      case (mMode)
         `STMC_MM_SELFLVL, `STMC_MM_FREERUN:
            mainSweepGo <= signalAdequate ? trigMain : 1'b1;
         `STMC_MM_ARMED:
            mainSweepGo <= trigMain;
         `STMC_MM_VLINE:
            mainSweepGo <= videoLine;
         `STMC_MM_VFIELD:
            mainSweepGo <= videoField;
         `STMC_MM_ONESHOT:
            mainSweepGo <= armedLamp && trigMain;
         default:
            mainSweepGo <= 1'b0;
      endcase
      if (mMode == `STMC_MM_ONESHOT && cmd[`STMC_CMD_MODEDN] && !sel) begin
         armedLamp   <= 1'b1;
         seqLeft_reg <= (seqLen_reg == 3'h0) ? 3'h1 : seqLen_reg;
         readoutOn   <= holdReadout_reg;
      end else if (mMode != `STMC_MM_ONESHOT) begin
         armedLamp   <= 1'b0;
         seqLeft_reg <= 3'h0;
         readoutOn   <= 1'b1;
      end else if (armedLamp && sweepDone) begin
         if (seqLeft_reg <= 3'h1) begin
            armedLamp    <= 1'b0;
            readoutOn    <= 1'b1;
            briefCnt_reg <= BRIEF_CYC;
         end
         seqLeft_reg <= seqLeft_reg - 3'h1;
      end else if (!holdReadout_reg && !armedLamp && briefCnt_reg != 32'h0) begin
         briefCnt_reg <= briefCnt_reg - 32'h1;
         if (briefCnt_reg == 32'h1)
            readoutOn <= 1'b0;
      end
   end
end

// --------------------------------------------------------------------
// delayed sweep control
// --------------------------------------------------------------------
assign dlyActive = intlDisp;
assign dlyTrigOk = splitTrace | mainSweepGo;

always @(posedge clk_sys or negedge reset_n) begin
   if (!reset_n) begin
      dlySweepGo <= 1'b0;
   end else if (!dlyActive || !delayExpired) begin
      dlySweepGo <= 1'b0;
   end else begin
      case (dMode)
         `STMC_DM_SELFLVL:
            dlySweepGo <= signalAdequate ? (trigDly && dlyTrigOk) : 1'b1;
         `STMC_DM_START:
            dlySweepGo <= 1'b1;
         `STMC_DM_ARMED:
            dlySweepGo <= trigDly && dlyTrigOk;
         `STMC_DM_VLINE:
            dlySweepGo <= videoLine && dlyTrigOk;
         default:
            dlySweepGo <= 1'b0;
      endcase
   end
end

// --------------------------------------------------------------------
// displayed-signal source resolution
// --------------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
   if (!reset_n) begin
      mainTrigSrc <= 3'h1;
      dlyTrigSrc  <= 3'h1;
      rotIdx_reg  <= 3'h1;
   end else begin
      if (mainSweepGo)
         rotIdx_reg <= (nextShown(chanShown_reg, sumOn_reg, rotIdx_reg + 3'h1) == 3'h0)
                       ? nextShown(chanShown_reg, sumOn_reg, 3'h1)
                       : nextShown(chanShown_reg, sumOn_reg, rotIdx_reg + 3'h1);
      if (src_reg[0] != `STMC_SRC_DISP)
         mainTrigSrc <= src_reg[0];
      else if (mMode == `STMC_MM_SELFLVL || timeSliced_reg || !intlDisp)
         mainTrigSrc <= sumOn_reg ? `STMC_SRC_SUM
                        : nextShown(chanShown_reg, 1'b0, 3'h1);
      else
         mainTrigSrc <= rotIdx_reg;
      if (src_reg[1] != `STMC_SRC_DISP)
         dlyTrigSrc <= src_reg[1];
      else if (dMode == `STMC_DM_SELFLVL || timeSliced_reg || !intlDisp)
         dlyTrigSrc <= sumOn_reg ? `STMC_SRC_SUM
                       : nextShown(chanShown_reg, 1'b0, 3'h1);
      else
         dlyTrigSrc <= rotIdx_reg;
   end
end

// --------------------------------------------------------------------
// measurements
// --------------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
   if (!reset_n) begin
      menuOn_reg    <= 1'b0;
      voltsOn_reg   <= 1'b0;
      timeOn_reg    <= 1'b0;
      voltsChan_reg <= 2'h1;
      ch2First_reg  <= 1'b0;
      delayChan_reg <= 3'h1;
      deltaChan_reg <= 3'h1;
      cursorHigh    <= {PEAKW{1'b0}};
      cursorLow     <= {PEAKW{1'b0}};
   end else begin
      if (wrEn && paddr == `STMC_ADDR_MEAS)
         menuOn_reg <= pwdata[0];
      if (wrEn && paddr == `STMC_ADDR_DISP)
         ch2First_reg <= pwdata[1] && !pwdata[0] ? 1'b1
                         : (!pwdata[1] ? 1'b0 : ch2First_reg);
      voltsChan_reg <= (chanShown_reg[1] && (!chanShown_reg[0] || ch2First_reg))
                       ? 2'h2 : 2'h1;
      delayChan_reg <= nextShown(chanShown_reg, sumOn_reg, 3'h1);
      deltaChan_reg <= (nextShown(chanShown_reg, sumOn_reg, delayChan_reg + 3'h1) == 3'h0)
                       ? delayChan_reg
                       : nextShown(chanShown_reg, sumOn_reg, delayChan_reg + 3'h1);
      if (cmd[`STMC_CMD_CLEAR]) begin
         menuOn_reg  <= 1'b0;
         voltsOn_reg <= 1'b0;
         timeOn_reg  <= 1'b0;
      end else begin
         if (cmd[`STMC_CMD_VOLTS] && !voltsOn_reg) begin
            voltsOn_reg <= 1'b1;
            cursorHigh  <= peakHigh;
            cursorLow   <= peakLow;
         end
         if (cmd[`STMC_CMD_TIME] && (!intlDisp || dMode == `STMC_DM_START))
            timeOn_reg <= 1'b1;
         else if (intlDisp && dMode != `STMC_DM_START)
            timeOn_reg <= 1'b0;
      end
   end
end

endmodule // stmc_sweep_trigger

// File: tb_top.sv
// self-checking bench for the sweep trigger mode controller
`timescale 1ns/1ps
`include "stmc_map.vh"
module tb_top;
   reg         clk_sys, reset_n, psel, penable, pwrite, runMain, doneReq;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, seed;
   reg  [3:0]  lat;
   reg  [7:0]  peakSet;
   reg  [63:0] e;
   wire [31:0] prdata;
   wire [7:0]  peakHigh, peakLow, cursorHigh, cursorLow;
   wire [2:0]  mainTrigSrc, dlyTrigSrc;
   wire        pready, pslverr, trigMain, trigDly, videoLine, videoField, signalAdequate;
   wire        levelEndStop, delayExpired, sweepDone, splitTrace, mainSweepGo, dlySweepGo;
   wire        levelAcquire, armedLamp, readoutOn;
   integer     errorCnt, checkCount, i;
   reg  [63:0] expQ[$];
   stmc_far_side stmc_far_side_inst (.clk_sys(clk_sys), .reset_n(reset_n), .runMain(runMain),
      .doneReq(doneReq), .lat(lat), .peakSet(peakSet), .trigMain(trigMain), .trigDly(trigDly),
      .videoLine(videoLine), .videoField(videoField), .signalAdequate(signalAdequate),
      .levelEndStop(levelEndStop), .delayExpired(delayExpired), .sweepDone(sweepDone),
      .splitTrace(splitTrace), .peakHigh(peakHigh), .peakLow(peakLow));
   stmc_sweep_trigger #(.BRIEF_CYC(10)) stmc_sweep_trigger_inst (.clk_sys(clk_sys),
      .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigMain(trigMain),
      .trigDly(trigDly), .videoLine(videoLine), .videoField(videoField),
      .signalAdequate(signalAdequate), .levelEndStop(levelEndStop), .delayExpired(delayExpired),
      .sweepDone(sweepDone), .splitTrace(splitTrace), .peakHigh(peakHigh), .peakLow(peakLow),
      .mainSweepGo(mainSweepGo), .dlySweepGo(dlySweepGo), .levelAcquire(levelAcquire),
      .armedLamp(armedLamp), .readoutOn(readoutOn), .mainTrigSrc(mainTrigSrc),
      .dlyTrigSrc(dlyTrigSrc), .cursorHigh(cursorHigh), .cursorLow(cursorLow));
   // --------------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------------
   task giveVerdict;
      begin
         $display("checks %0d mismatches %0d", checkCount, errorCnt);
         if (errorCnt == 0 && checkCount > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp, input [31:0] mask);
      begin
         checkCount = checkCount + 1;
         if (((got ^ exp) & mask) !== 32'h0) begin
            errorCnt = errorCnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task xfer(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk_sys);
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= a;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clk_sys);
            n = n + 1;
         end while (pready !== 1'b1 && n < 50);
         psel    <= 1'b0;
         penable <= 1'b0;
         if (n >= 50) begin
            errorCnt = errorCnt + 1;
            giveVerdict;
         end
      end
   endtask
   task rd(input [11:0] a, input [31:0] exp, input [31:0] mask);
      begin
         expQ.push_back({mask, exp});
         xfer(1'b0, a, 32'h0);
      end
   endtask
   task cmd(input integer b);
      xfer(1'b1, `STMC_ADDR_CMD, 32'h1 << b);
   endtask
   task trace;
      begin
         @(posedge clk_sys);
         doneReq <= 1'b1;
         @(posedge clk_sys);
         doneReq <= 1'b0;
         repeat (14) @(posedge clk_sys);
      end
   endtask
   // read results are compared when the access phase completes
   always @(posedge clk_sys) begin
      if (psel && penable && !pwrite && pready && expQ.size() > 0) begin
         e = expQ.pop_front();
         cmp(prdata, e[31:0], e[63:32]);
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // --------------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------------
   initial begin
      {reset_n, psel, penable, pwrite, runMain, doneReq} = 6'h00;
      {paddr, pwdata, lat, errorCnt, checkCount} = 0;
      seed = 32'hCDE4;
      lat = 4'h1;
      peakSet = 8'h00;
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(`STMC_ADDR_MAINCFG, 32'h000, 32'h1FF);
      rd(`STMC_ADDR_DLYCFG, 32'h001, 32'h1FF);
      rd(`STMC_ADDR_CTRL, 32'h10, 32'h7F);
      xfer(1'b1, 12'h01C, $random(seed));
      rd(12'h01C, 32'h0, 32'hFFFFFFFF);
      xfer(1'b1, `STMC_ADDR_DISP, 32'h6);
      repeat (2) @(posedge clk_sys);
      rd(`STMC_ADDR_MEAS, 32'h350, 32'h7F8);
      cmp({29'h0, mainTrigSrc}, 32'h2, 32'h7);
      cmp({29'h0, dlyTrigSrc}, 32'h2, 32'h7);
      xfer(1'b1, `STMC_ADDR_MAINCFG, 32'h3);
      rd(`STMC_ADDR_MAINCFG, 32'h0, 32'h7);
      for (i = 0; i < 7; i = i + 1) begin
         cmd(`STMC_CMD_MODEDN);
         cmd(`STMC_CMD_SRCUP);
         cmd(`STMC_CMD_CPLUP);
      end
      rd(`STMC_ADDR_MAINCFG, 32'h12D, 32'h1FF);
      xfer(1'b1, `STMC_ADDR_CTRL, 32'h22);
      rd(`STMC_ADDR_STATUS, 32'h1, 32'h1);
      rd(`STMC_ADDR_DLYCFG, 32'h201, 32'h3FF);
      for (i = 0; i < 4; i = i + 1) cmd(`STMC_CMD_MODEDN);
      rd(`STMC_ADDR_DLYCFG, 32'h3, 32'h7);
      cmd(`STMC_CMD_SLOPE);
      rd(`STMC_ADDR_DLYCFG, 32'h0, 32'h200);
      rd(`STMC_ADDR_MAINCFG, 32'h32D, 32'h3FF);
      cmd(`STMC_CMD_MODEUP);
      cmd(`STMC_CMD_MODEUP);
      cmd(`STMC_CMD_TIME);
      rd(`STMC_ADDR_MEAS, 32'h4, 32'h4);
      cmd(`STMC_CMD_MODEDN);
      rd(`STMC_ADDR_MEAS, 32'h0, 32'h4);
      cmd(`STMC_CMD_MODEUP);
      repeat (30) @(posedge clk_sys);
      cmp({31'h0, dlySweepGo}, 32'h0, 32'h1);
      lat <= 4'h6;
      runMain <= 1'b1;
      for (i = 0; i < 100 && dlySweepGo !== 1'b1; i = i + 1) @(posedge clk_sys);
      cmp({31'h0, dlySweepGo}, 32'h1, 32'h1);
      runMain <= 1'b0;
      xfer(1'b1, `STMC_ADDR_CTRL, 32'h20);
      rd(`STMC_ADDR_STATUS, 32'h0, 32'h1);
      for (i = 0; i < 2; i = i + 1) begin
         lat <= i ? 4'h9 : 4'h1;
         cmd(`STMC_CMD_MODEDN);
         rd(`STMC_ADDR_STATUS, 32'h24, 32'h74);
         trace;
         rd(`STMC_ADDR_STATUS, 32'h4, 32'h4);
         trace;
         rd(`STMC_ADDR_STATUS, 32'h0, 32'h4);
         repeat (30) @(posedge clk_sys);
         rd(`STMC_ADDR_STATUS, i ? 32'h8 : 32'h0, 32'h8);
         xfer(1'b1, `STMC_ADDR_CTRL, 32'h28);
      end
      peakSet <= $random(seed);
      cmd(`STMC_CMD_VOLTS);
      repeat (3) @(posedge clk_sys);
      cmp({24'h0, cursorHigh}, {24'h0, peakSet}, 32'hFF);
      cmp({24'h0, cursorLow}, {24'h0, peakSet >> 1}, 32'hFF);
      rd(`STMC_ADDR_MEAS, 32'h2, 32'h2);
      xfer(1'b1, `STMC_ADDR_MEAS, 32'h1);
      cmd(`STMC_CMD_CLEAR);
      rd(`STMC_ADDR_MEAS, 32'h0, 32'h7);
      repeat (3) @(posedge clk_sys);
      giveVerdict;
   end
endmodule // tb_top
